// File: core/crs_pkg.sv
// package: register map, field layout and reset values of the collision and mode registers
package crs_pkg;
  localparam int          APB_AW         = 8;
  // register indices; byte address is four times the index
  localparam logic [5:0]  IDX_COLL       = 6'h0E;
  localparam logic [5:0]  IDX_RSVD0      = 6'h0F;
  localparam logic [5:0]  IDX_RSVD1      = 6'h10;
  localparam logic [5:0]  IDX_MODE       = 6'h11;
  localparam logic [5:0]  IDX_IRQ_STAT   = 6'h20;
  localparam logic [5:0]  IDX_IRQ_MASK   = 6'h21;
  localparam logic [5:0]  IDX_LIVE       = 6'h22;
  // collision_report fields
  localparam int          COLL_KEEP_BIT  = 7;
  localparam int          COLL_INVAL_BIT = 5;
  localparam logic [7:0]  COLL_RST       = 8'hA0;
  // general_mode fields
  localparam int          MODE_MSB_BIT   = 7;
  localparam int          MODE_TXW_BIT   = 5;
  localparam int          MODE_POL_BIT   = 3;
  localparam int          MODE_PRE_LSB   = 0;
  localparam logic [7:0]  MODE_RST       = 8'h3F;
  localparam logic [7:0]  MODE_WMASK     = 8'hAB;
  // crc presets
  localparam logic [15:0] CRC_PRE_00     = 16'h0000;
  localparam logic [15:0] CRC_PRE_01     = 16'h6363;
  localparam logic [15:0] CRC_PRE_10     = 16'hA671;
  localparam logic [15:0] CRC_PRE_11     = 16'hFFFF;
  // interrupt status bits
  localparam int          IRQ_ENV        = 0;
  localparam int          IRQ_COLL       = 1;
  localparam int          IRQ_TXREF      = 2;
  localparam int          IRQ_FEND       = 3;
  localparam int          IRQ_N          = 4;
  localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;
  // collision position counting
  localparam logic [5:0]  POS_LIMIT      = 6'h20;
  localparam logic [5:0]  CNT_SAT        = 6'h21;
endpackage

// File: core/crs_sync_if.sv
// interface: raw asynchronous levels and their synchronised copies
interface crs_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport owner (output raw, input synced);
  modport sync  (input raw, output synced);
endinterface

// File: core/crs_sync2.sv
// module: two flip-flop synchroniser for asynchronous levels
module crs_sync2 #(
  parameter int W = 1
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  crs_sync_if.sync  s
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } crs_sync_state_t;

  crs_sync_state_t q_r;
  crs_sync_state_t q_nxt;

  // stage1 feeds stage2 only
  always_comb begin
    q_nxt        = q_r;
    q_nxt.stage1 = s.raw;
    q_nxt.stage2 = q_r.stage1;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign s.synced = q_r.stage2;
endmodule // crs_sync2

// File: core/crs_regs.sv
// module: collision report and general mode registers behind an APB slave
// Functional notes
// - keep flag 0: received bits after a collision are stored as zero
// - invalid flag set when no collision or position beyond five-bit range
// - read-only five-bit position of first collision, data bits only
// - position is one-based; code 0 means the thirty-second bit
// - bit-order 1: crc computed high bit first, results bit reversed
// - bit-order control ignored during rf communication
// - transmit-wait set: transmitter starts only with rf field present
// - polarity bit 1 makes envelope pin active high, 0 active low
// - internal envelope active low; polarity change raises envelope event
// - preset select 00/01/10/11 gives 0000/6363/A671/FFFF for crc compute
// - during rf communication preset follows receive and transmit modes; code picks FFFF/6363 from tx_framing_b_i only
module crs_regs
  import crs_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [APB_AW-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic                   irq_o,
  // receiver side
  input  wire logic              rx_frame_start_i,
  input  wire logic              rx_frame_end_i,
  input  wire logic              rx_bit_valid_i,
  input  wire logic              rx_bit_i,
  input  wire logic              rx_bit_coll_i,
  output logic                   rx_store_o,
  output logic                   rx_data_o,
  // transmitter side
  input  wire logic              rf_comm_i,
  input  wire logic              rf_field_i,
  input  wire logic              tx_req_i,
  output logic                   tx_start_o,
  // crc coprocessor side
  input  wire logic              tx_framing_b_i,
  input  wire logic              crc_compute_command_i,
  output logic                   crc_load_o,
  output logic      [15:0]       crc_preset_o,
  output logic                   crc_high_bit_leading_o,
  // envelope pin
  input  wire logic              envelope_input_pin_i,
  output logic                   envelope_n_o
);
  typedef struct packed {
    logic              keep;
    logic              inval;
    logic [4:0]        pos;
    logic [7:0]        mode;
    logic [5:0]        bit_cnt;
    logic              coll_seen;
    logic              frame_active;
    logic [IRQ_N-1:0]  irq_stat;
    logic [IRQ_N-1:0]  irq_mask;
    logic              irq;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              tx_start;
    logic              rx_store;
    logic              rx_data;
    logic              crc_load;
    logic [15:0]       crc_preset;
    logic              crc_msb;
    logic              env_n;
  } crs_state_t;

  localparam crs_state_t STATE_RST = '{
    keep:         COLL_RST[COLL_KEEP_BIT],
    inval:        COLL_RST[COLL_INVAL_BIT],
    pos:          COLL_RST[4:0],
    mode:         MODE_RST,
    bit_cnt:      '0,
    coll_seen:    1'b0,
    frame_active: 1'b0,
    irq_stat:     '0,
    irq_mask:     IRQ_MASK_RST,
    irq:          1'b0,
    prdata:       '0,
    pready:       1'b0,
    pslverr:      1'b0,
    tx_start:     1'b0,
    rx_store:     1'b0,
    rx_data:      1'b0,
    crc_load:     1'b0,
    crc_preset:   CRC_PRE_11,
    crc_msb:      1'b0,
    env_n:        1'b1
  };

  crs_state_t q_r;
  crs_state_t q_nxt;

  crs_sync_if #(.W(1)) env_sync ();

  assign env_sync.raw = envelope_input_pin_i;

  crs_sync2 #(
    .W (1)
  ) u_env_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .s         (env_sync)
  );

  logic [5:0]       idx;
  logic             setup;
  logic             access;
  logic             wr;
  logic             rd_stat;
  logic [IRQ_N-1:0] set_v;
  logic [5:0]       cnt_inc;
  logic [7:0]       mode_new;

  assign idx = paddr_i[7:2];

  always_comb begin
    q_nxt      = q_r;
    set_v      = '0;
    cnt_inc    = q_r.bit_cnt;
    mode_new   = q_r.mode;
    setup      = psel_i & ~penable_i;
    access     = psel_i & penable_i & q_r.pready;
    wr         = access & pwrite_i & pstrb_i[0];
    rd_stat    = access & ~pwrite_i & (idx == IDX_IRQ_STAT) & ~q_r.pslverr;
    q_nxt.pready   = 1'b0;
    // error flag stands only beside ready, never past the access cycle
    q_nxt.pslverr  = 1'b0;
    q_nxt.tx_start = 1'b0;
    q_nxt.rx_store = 1'b0;
    q_nxt.crc_load = 1'b0;

    // read data is captured in setup so prdata comes from a flop; one wait-free access
    if (setup) begin
      q_nxt.pready  = 1'b1;
      q_nxt.pslverr = 1'b0;
      q_nxt.prdata  = '0;
      case (idx)
        IDX_COLL: begin
          q_nxt.prdata[7:0] = {q_r.keep, 1'b0, q_r.inval, q_r.pos};
        end
        IDX_RSVD0, IDX_RSVD1: begin
          q_nxt.prdata = '0;
        end
        IDX_MODE: begin
          q_nxt.prdata[7:0] = q_r.mode & MODE_WMASK;
        end
        IDX_IRQ_STAT: begin
          q_nxt.prdata[IRQ_N-1:0] = q_r.irq_stat;
        end
        IDX_IRQ_MASK: begin
          q_nxt.prdata[IRQ_N-1:0] = q_r.irq_mask;
        end
        IDX_LIVE: begin
          q_nxt.prdata[2:0] = {q_r.frame_active, q_r.coll_seen, q_r.env_n};
        end
        default: begin
          q_nxt.pslverr = 1'b1;
        end
      endcase
    end

    // register writes take effect at the completing edge
    if (wr && !q_r.pslverr) begin
      case (idx)
        IDX_COLL: begin
          q_nxt.keep = pwdata_i[COLL_KEEP_BIT];
        end
        IDX_MODE: begin
          mode_new   = (pwdata_i[7:0] & MODE_WMASK) | (q_r.mode & ~MODE_WMASK);
          q_nxt.mode = mode_new;
          if (mode_new[MODE_POL_BIT] != q_r.mode[MODE_POL_BIT]) begin
            set_v[IRQ_ENV] = 1'b1;
          end
        end
        IDX_IRQ_MASK: begin
          q_nxt.irq_mask = pwdata_i[IRQ_N-1:0];
        end
        default: begin
          q_nxt.mode = q_r.mode;
        end
      endcase
    end

    // collision tracking over data bits only; framing strips parity upstream
    if (rx_frame_start_i) begin
      q_nxt.bit_cnt      = '0;
      q_nxt.coll_seen    = 1'b0;
      q_nxt.inval        = 1'b1;
      q_nxt.pos          = '0;
      q_nxt.frame_active = 1'b1;
    end else if (rx_bit_valid_i && q_r.frame_active) begin
      cnt_inc = (q_r.bit_cnt == CNT_SAT) ? q_r.bit_cnt : q_r.bit_cnt + 6'h01;
      q_nxt.bit_cnt  = cnt_inc;
      q_nxt.rx_store = 1'b1;
      // bits after the first collision are zeroed unless software keeps them
      q_nxt.rx_data  = (q_r.coll_seen && !q_r.keep) ? 1'b0 : rx_bit_i;
      if (rx_bit_coll_i && !q_r.coll_seen) begin
        q_nxt.coll_seen     = 1'b1;
        set_v[IRQ_COLL]     = 1'b1;
        if (cnt_inc <= POS_LIMIT) begin
          q_nxt.inval = 1'b0;
          q_nxt.pos   = cnt_inc[4:0];
        end
      end
    end
    if (rx_frame_end_i && !rx_frame_start_i) begin
      q_nxt.frame_active = 1'b0;
      set_v[IRQ_FEND]    = 1'b1;
    end

    // transmit interlock on the rf field
    if (tx_req_i) begin
      if (!q_r.mode[MODE_TXW_BIT] || rf_field_i) begin
        q_nxt.tx_start = 1'b1;
      end else begin
        set_v[IRQ_TXREF] = 1'b1;
      end
    end

    // envelope: pin active when it equals the polarity bit; internal copy active low
    q_nxt.env_n = env_sync.synced[0] ^ q_r.mode[MODE_POL_BIT];
    if (q_r.env_n && !q_nxt.env_n) begin
      set_v[IRQ_ENV] = 1'b1;
    end

    // crc preset and bit order
    q_nxt.crc_load = crc_compute_command_i & ~rf_comm_i;
    if (rf_comm_i) begin
      q_nxt.crc_preset = tx_framing_b_i ? CRC_PRE_11 : CRC_PRE_01;
      q_nxt.crc_msb    = 1'b0;
    end else begin
      q_nxt.crc_msb = q_r.mode[MODE_MSB_BIT];
      unique case (q_r.mode[MODE_PRE_LSB +: 2])
        2'b00: q_nxt.crc_preset = CRC_PRE_00;
        2'b01: q_nxt.crc_preset = CRC_PRE_01;
        2'b10: q_nxt.crc_preset = CRC_PRE_10;
        2'b11: q_nxt.crc_preset = CRC_PRE_11;
      endcase
    end

    // read clears only bits that were reported, so a set in the same cycle survives
    q_nxt.irq_stat = (q_r.irq_stat & ~(rd_stat ? q_r.prdata[IRQ_N-1:0] : '0)) | set_v;
    q_nxt.irq      = |(q_nxt.irq_stat & q_nxt.irq_mask);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r <= STATE_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign prdata_o               = q_r.prdata;
  assign pready_o               = q_r.pready;
  assign pslverr_o              = q_r.pslverr;
  assign irq_o                  = q_r.irq;
  assign rx_store_o             = q_r.rx_store;
  assign rx_data_o              = q_r.rx_data;
  assign tx_start_o             = q_r.tx_start;
  assign crc_load_o             = q_r.crc_load;
  assign crc_preset_o           = q_r.crc_preset;
  assign crc_high_bit_leading_o = q_r.crc_msb;
  assign envelope_n_o           = q_r.env_n;
endmodule // crs_regs

// File: verification/crs_checker.sv
// checker: port timing relations of the collision and mode register slice
module crs_checker
  import crs_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [31:0] prdata_o,
  input wire logic        tx_req_i,
  input wire logic        rf_field_i,
  input wire logic        tx_start_o,
  input wire logic        rf_comm_i,
  input wire logic        tx_framing_b_i,
  input wire logic        crc_compute_command_i,
  input wire logic        crc_load_o,
  input wire logic [15:0] crc_preset_o,
  input wire logic        crc_high_bit_leading_o,
  input wire logic        rx_bit_valid_i,
  input wire logic        rx_store_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  ready_after_setup_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  error_with_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  upper_data_zero_a: assert property (pready_o |-> prdata_o[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  tx_field_start_a: assert property (tx_req_i && rf_field_i |=> tx_start_o)
    else $error("start refused with field on");
  tx_start_cause_a: assert property (tx_start_o |-> $past(tx_req_i))
    else $error("start without request");
  crc_load_gate_a: assert property (crc_compute_command_i |=> crc_load_o == !$past(rf_comm_i))
    else $error("crc load gating wrong");
  rf_msb_off_a: assert property (rf_comm_i |=> !crc_high_bit_leading_o)
    else $error("bit order honoured during rf");
  rf_preset_auto_a: assert property (rf_comm_i |=>
    crc_preset_o == ($past(tx_framing_b_i) ? 16'hFFFF : 16'h6363))
    else $error("rf preset wrong");
  store_after_bit_a: assert property (rx_store_o |-> $past(rx_bit_valid_i))
    else $error("store without bit");
endmodule // crs_checker
bind crs_regs crs_checker chk (.clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pready_o,
  .pslverr_o, .prdata_o, .tx_req_i, .rf_field_i, .tx_start_o, .rf_comm_i, .tx_framing_b_i,
  .crc_compute_command_i, .crc_load_o, .crc_preset_o, .crc_high_bit_leading_o,
  .rx_bit_valid_i, .rx_store_o);

// File: verification/crs_host.sv
// host model: apb requester for the register slice
module crs_host (
  input  wire logic        clk_sys_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  input  wire logic [31:0] prdata_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rd_r = 32'h0000_0000;
  logic        err_r = 1'b0;
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
  end
  // starts on a fresh edge so a release and a new setup never share a time step
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d,
                      output logic ok);
    int n;
    @(posedge clk_sys_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= {idx, 2'b00};
    pwdata_o <= {24'h00_0000, d};
    @(posedge clk_sys_i);
    penable_o <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (!pready_i && n < 50);
    ok = pready_i;
    rd_r = prdata_i;
    err_r = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule // crs_host

// File: verification/tb_top.sv
// testbench: collision report, mode register and interrupt scenarios
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import crs_pkg::*;
  logic clk_sys_i = 0, rst_n_i = 0, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
  logic rx_frame_start_i = 0, rx_frame_end_i = 0, rx_bit_valid_i = 0, rx_bit_i = 0;
  logic rx_bit_coll_i = 0, rx_store_o, rx_data_o, rf_comm_i = 0, rf_field_i = 0;
  logic tx_req_i = 0, tx_start_o, tx_framing_b_i = 0, crc_compute_command_i = 0, crc_load_o;
  logic crc_high_bit_leading_o, envelope_input_pin_i = 0, envelope_n_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic [15:0] crc_preset_o;
  int error_cnt = 0;
  int check_count = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  crs_regs uut (.clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i(4'hF), .prdata_o, .pready_o, .pslverr_o, .irq_o, .rx_frame_start_i,
    .rx_frame_end_i, .rx_bit_valid_i, .rx_bit_i, .rx_bit_coll_i, .rx_store_o, .rx_data_o,
    .rf_comm_i, .rf_field_i, .tx_req_i, .tx_start_o, .tx_framing_b_i, .crc_compute_command_i,
    .crc_load_o, .crc_preset_o, .crc_high_bit_leading_o, .envelope_input_pin_i, .envelope_n_o);
  crs_host host (.clk_sys_i, .pready_i(pready_o), .pslverr_i(pslverr_o), .prdata_i(prdata_o),
    .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
    .pwdata_o(pwdata_i));
  task automatic wrap_up();
    if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
    logic ok;
    host.xfer(w, i, d, ok);
    if (ok !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task automatic t_reset();
    bus(0, IDX_COLL, 8'h00);
    chk("coll", host.rd_r, 32'h0000_00A0);
    bus(0, IDX_MODE, 8'h00);
    chk("mode", host.rd_r, 32'h0000_002B);
    for (int k = 0; k < 2; k++) begin
      bus(1, k ? IDX_RSVD1 : IDX_RSVD0, 8'hFF);
      bus(0, k ? IDX_RSVD1 : IDX_RSVD0, 8'h00);
      chk("rsvd", host.rd_r, 32'h0000_0000);
    end
    bus(0, 6'h3F, 8'h00);
    chk("unmapped", {31'h0, host.err_r}, 32'h0000_0001);
  endtask
  // every bit is a one; a second collision three bits later, driven when p + 3 is within the 34 bits, must not move the position
  task automatic frame(input int p, input logic keep);
    @(posedge clk_sys_i) rx_frame_start_i <= 1;
    @(posedge clk_sys_i) rx_frame_start_i <= 0;
    for (int b = 1; b <= 34; b++) begin
      rx_bit_valid_i <= 1;
      rx_bit_i <= 1;
      rx_bit_coll_i <= (b == p || b == p + 3);
      @(posedge clk_sys_i) rx_bit_valid_i <= 0;
      rx_bit_coll_i <= 0;
      @(posedge clk_sys_i);
      chk("store", {31'h0, rx_store_o}, 32'h0000_0001);
      chk("data", {31'h0, rx_data_o}, {31'h0, b <= p || keep});
    end
    rx_frame_end_i <= 1;
    @(posedge clk_sys_i) rx_frame_end_i <= 0;
    bus(0, IDX_COLL, 8'h00);
    if (p > 32) chk("coll", host.rd_r & 32'hE0, {keep, 7'h20});
    else chk("coll", host.rd_r, {24'h0, keep, 2'b00, 5'(p % 32)});
    chk("irq", {31'h0, irq_o}, 32'h0000_0001);
    bus(0, IDX_IRQ_STAT, 8'h00);
    chk("stat", host.rd_r, 32'h0000_000A);
    repeat (2) @(posedge clk_sys_i);
    chk("irq", {31'h0, irq_o}, 32'h0000_0000);
  endtask
  task automatic t_env();
    envelope_input_pin_i <= 1;
    repeat (5) @(posedge clk_sys_i);
    chk("env", {31'h0, envelope_n_o}, 32'h0000_0000);
    bus(0, IDX_IRQ_STAT, 8'h00);
    bus(1, IDX_MODE, 8'h03);
    repeat (5) @(posedge clk_sys_i);
    chk("env", {31'h0, envelope_n_o}, 32'h0000_0001);
    bus(0, IDX_IRQ_STAT, 8'h00);
    chk("env evt", {31'h0, host.rd_r[IRQ_ENV]}, 32'h0000_0001);
    envelope_input_pin_i <= 0;
    repeat (5) @(posedge clk_sys_i);
    chk("env", {31'h0, envelope_n_o}, 32'h0000_0000);
  endtask
  task automatic tx(input logic m, input logic f, input logic e);
    bus(1, IDX_MODE, {2'b00, m, 5'h00});
    rf_field_i <= f;
    tx_req_i <= 1;
    @(posedge clk_sys_i) tx_req_i <= 0;
    @(posedge clk_sys_i);
    chk("tx start", {31'h0, tx_start_o}, {31'h0, e});
    bus(0, IDX_IRQ_STAT, 8'h00);
    chk("tx refused", {31'h0, host.rd_r[IRQ_TXREF]}, {31'h0, !e});
  endtask
  task automatic crc(input logic [7:0] m, input logic [15:0] ep, input logic el, em);
    bus(1, IDX_MODE, m);
    crc_compute_command_i <= 1;
    @(posedge clk_sys_i) crc_compute_command_i <= 0;
    @(posedge clk_sys_i);
    chk("load", {31'h0, crc_load_o}, {31'h0, el});
    chk("preset", {16'h0, crc_preset_o}, {16'h0, ep});
    chk("msb", {31'h0, crc_high_bit_leading_o}, {31'h0, em});
  endtask
  initial begin
    static logic [15:0] pre [4] = '{CRC_PRE_00, CRC_PRE_01, CRC_PRE_10, CRC_PRE_11};
    static int ps [4] = '{1, 8, 32, 33};
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1;
    t_reset();
    bus(1, IDX_IRQ_MASK, 8'h02);
    bus(1, IDX_COLL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) bus(1, IDX_COLL, 8'h80);
      frame(ps[i], i >= 2);
    end
    t_env();
    tx(1, 0, 0);
    tx(1, 1, 1);
    tx(0, 0, 1);
    for (int p = 0; p < 4; p++) crc(8'h80 | 8'(p), pre[p], 1, 1);
    rf_comm_i <= 1;
    crc(8'h80, 16'h6363, 0, 0);
    tx_framing_b_i <= 1;
    crc(8'h80, 16'hFFFF, 0, 0);
    wrap_up();
  end
endmodule // tb_top
